// ### rtl/rhp_host_port.sv
// Parallel and serial host port of the angle converter
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Frame is 16 data then 8 fault bits
// - Output bit changes after serial clock rise
// - Input bit captured on serial clock fall
// - Serial output driven only while frame low
// - Parallel bus driven only when read and select low
// - Serial select low serial, high parallel
// - Sample fall latches position, velocity, fault
module rhp_host_port (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [rhp_pkg::POS_W-1:0] POSITION_IN,
    input wire logic [rhp_pkg::POS_W-1:0] VELOCITY_IN,
    input wire logic [rhp_pkg::FAULT_W-1:0] FAULT_IN,
    input wire logic SAMPLE_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_N,
    input wire logic WRITE_STROBE_FRAME_SYNC_N,
    input wire logic SERIAL_PORT_SELECT,
    input wire logic MODE_SELECT_LOW,
    input wire logic MODE_SELECT_HIGH,
    input wire logic [rhp_pkg::POS_W-1:0] PARALLEL_DATA_LINES_IN,
    output logic [rhp_pkg::POS_W-1:0] PARALLEL_DATA_LINES_OUT,
    output logic PARALLEL_DATA_LINES_OE,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OE,
    output logic [rhp_pkg::CFG_DATA_W-1:0] CONFIG_ADDR,
    output logic [rhp_pkg::CFG_DATA_W-1:0] CONFIG_DATA,
    output logic CONFIG_WRITE,
    output logic [rhp_pkg::CFG_DATA_W-1:0] SERIAL_RX_WORD,
    output logic SERIAL_RX_VALID
);
    import rhp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // System clock domain state
    typedef struct packed {
        logic [2:0] sample_sync;
        logic [2:0] wr_sync;
        logic [1:0] rd_sync;
        logic [1:0] cs_sync;
        logic [1:0] sel_sync;
        logic [1:0] ml_sync;
        logic [1:0] mh_sync;
        logic [POS_W-1:0] pos_hold;
        logic [POS_W-1:0] vel_hold;
        logic [FAULT_W-1:0] fault_hold;
        logic addr_phase;
        logic [CFG_DATA_W-1:0] cfg_addr;
        logic [CFG_DATA_W-1:0] cfg_data;
        logic cfg_wr;
        logic [POS_W-1:0] par_out;
        logic par_oe;
        logic [2:0] rx_tog_sync;
        logic [CFG_DATA_W-1:0] rx_word;
        logic rx_valid;
    } rhp_sys_s;

    rhp_sys_s s_reg, s_next;

    // Link side state, clocked by the serial clock
    typedef struct packed {
        logic [CNT_W-1:0] bit_cnt;
        logic [FRAME_BITS-1:0] shift_out;
        logic [CFG_DATA_W-1:0] shift_in;
        logic [CFG_DATA_W-1:0] rx_word;
        logic rx_tog;
    } rhp_link_s;

    rhp_link_s l_reg, l_next;
    rhp_link_s l_fall_reg, l_fall_next;
    logic sdo_reg, sdo_next;

    function automatic logic [POS_W-1:0] rhp_select(input logic [1:0] mode,
                                                  input logic [POS_W-1:0] pos,
                                                  input logic [POS_W-1:0] vel);
        rhp_select = (mode == MODE_VELOCITY) ? vel : pos;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // System domain logic
    logic sample_fall, wr_rise, par_mode, par_rd, cfg_mode;
    logic [1:0] mode_s;

    always_comb begin
        s_next = s_reg;
        s_next.sample_sync = {s_reg.sample_sync[1:0], SAMPLE_N};
        s_next.wr_sync = {s_reg.wr_sync[1:0], WRITE_STROBE_FRAME_SYNC_N};
        s_next.rd_sync = {s_reg.rd_sync[0], READ_N};
        s_next.cs_sync = {s_reg.cs_sync[0], CHIP_SELECT_N};
        s_next.sel_sync = {s_reg.sel_sync[0], SERIAL_PORT_SELECT};
        s_next.ml_sync = {s_reg.ml_sync[0], MODE_SELECT_LOW};
        s_next.mh_sync = {s_reg.mh_sync[0], MODE_SELECT_HIGH};
        s_next.rx_tog_sync = {s_reg.rx_tog_sync[1:0], l_fall_reg.rx_tog};
        sample_fall = s_reg.sample_sync[2] & ~s_reg.sample_sync[1];
        wr_rise = ~s_reg.wr_sync[2] & s_reg.wr_sync[1];
        par_mode = s_reg.sel_sync[1];
        mode_s = {s_reg.mh_sync[1], s_reg.ml_sync[1]};
        cfg_mode = (mode_s == MODE_CONFIG);
        s_next.cfg_wr = 1'b0;
        s_next.rx_valid = 1'b0;
        if (sample_fall) begin
            s_next.pos_hold = POSITION_IN;
            s_next.vel_hold = VELOCITY_IN;
            s_next.fault_hold = FAULT_IN;
        end
        // Parallel write: address first, then data; host keeps the spacing
        if (par_mode && wr_rise && !s_reg.cs_sync[1] && cfg_mode) begin
            if (!s_reg.addr_phase) begin
                s_next.cfg_addr = PARALLEL_DATA_LINES_IN[CFG_DATA_W-1:0];
                s_next.addr_phase = 1'b1;
            end else begin
                s_next.cfg_data = PARALLEL_DATA_LINES_IN[CFG_DATA_W-1:0];
                s_next.addr_phase = 1'b0;
                s_next.cfg_wr = 1'b1;
            end
        end
        par_rd = par_mode && !s_reg.rd_sync[1] && !s_reg.cs_sync[1];
        s_next.par_oe = par_rd;
        if (par_rd) begin
            s_next.par_out = cfg_mode ? {{(POS_W-FAULT_W){1'b0}}, s_reg.fault_hold} :
                rhp_select(mode_s, s_reg.pos_hold, s_reg.vel_hold);
        end
        if (s_reg.rx_tog_sync[2] != s_reg.rx_tog_sync[1]) begin
            s_next.rx_word = l_fall_reg.rx_word;
            s_next.rx_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.sample_sync <= 3'h7;
            s_reg.wr_sync <= 3'h7;
            s_reg.rd_sync <= 2'h3;
            s_reg.cs_sync <= 2'h3;
            s_reg.pos_hold <= POS_RESET;
            s_reg.vel_hold <= POS_RESET;
            s_reg.fault_hold <= FAULT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial link logic
    // Frame sync low is the frame; its rise acts as an asynchronous reset
    // so no serial clock edge is needed to close the frame.
    logic frame_rst;
    assign frame_rst = RST | WRITE_STROBE_FRAME_SYNC_N | SERIAL_PORT_SELECT;

    // Held words change only on sample falls, which the host keeps well
    // clear of the frame start, so they are quasi-static here.
    always_comb begin
        l_next = l_reg;
        sdo_next = sdo_reg;
        if (l_reg.bit_cnt == '0) begin
            l_next.shift_out = {rhp_select({MODE_SELECT_HIGH, MODE_SELECT_LOW},
                                           s_reg.pos_hold, s_reg.vel_hold),
                                s_reg.fault_hold};
            sdo_next = l_next.shift_out[FRAME_BITS-1];
            l_next.shift_out = {l_next.shift_out[FRAME_BITS-2:0], 1'b0};
            l_next.bit_cnt = CNT_W'(1);
        end else if (l_reg.bit_cnt < CNT_W'(FRAME_BITS)) begin
            sdo_next = l_reg.shift_out[FRAME_BITS-1];
            l_next.shift_out = {l_reg.shift_out[FRAME_BITS-2:0], 1'b0};
            l_next.bit_cnt = l_reg.bit_cnt + CNT_W'(1);
        end else begin
            sdo_next = 1'b0;
        end
    end

    always_ff @(posedge SERIAL_CLK or posedge frame_rst) begin
        if (frame_rst) begin
            l_reg <= '0;
            sdo_reg <= 1'b0;
        end else begin
            l_reg <= l_next;
            sdo_reg <= sdo_next;
        end
    end

    // Input capture on falling edge; the toggle survives frame resets
    logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
    always_comb begin
        l_fall_next = l_fall_reg;
        rx_cnt_next = rx_cnt_reg + CNT_W'(1);
        l_fall_next.shift_in = {l_fall_reg.shift_in[CFG_DATA_W-2:0], SERIAL_DATA_IN};
        // Every eighth bit closes a word, so a frame yields one word per byte
        if (rx_cnt_reg == CNT_W'(CFG_DATA_W - 1)) begin
            l_fall_next.rx_word = l_fall_next.shift_in;
            l_fall_next.rx_tog = ~l_fall_reg.rx_tog;
            rx_cnt_next = '0;
        end
    end

    always_ff @(negedge SERIAL_CLK or posedge RST) begin
        if (RST) begin
            l_fall_reg <= '0;
        end else begin
            l_fall_reg <= l_fall_next;
        end
    end

    always_ff @(negedge SERIAL_CLK or posedge frame_rst) begin
        if (frame_rst) begin
            rx_cnt_reg <= '0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive
    // Drive starts at the first bit; ends asynchronously on frame rise
    assign SERIAL_DATA_OUT = sdo_reg;
    assign SERIAL_DATA_OE = (l_reg.bit_cnt != '0) & ~frame_rst;
    assign PARALLEL_DATA_LINES_OUT = s_reg.par_out;
    assign PARALLEL_DATA_LINES_OE = s_reg.par_oe;
    assign CONFIG_ADDR = s_reg.cfg_addr;
    assign CONFIG_DATA = s_reg.cfg_data;
    assign CONFIG_WRITE = s_reg.cfg_wr;
    assign SERIAL_RX_WORD = s_reg.rx_word;
    assign SERIAL_RX_VALID = s_reg.rx_valid;
endmodule
`default_nettype wire

// ### rtl/rhp_pkg.sv
// Shared constants for the converter host port
package rhp_pkg;
    localparam int POS_W = 16;
    localparam int FAULT_W = 8;
    localparam int FRAME_BITS = 24;
    localparam int SHORT_BITS = 16;
    localparam int CFG_DATA_W = 8;
    localparam int CNT_W = 5;
    localparam logic [1:0] MODE_POSITION = 2'h0;
    localparam logic [1:0] MODE_VELOCITY = 2'h1;
    localparam logic [1:0] MODE_CONFIG = 2'h3;
    localparam logic [POS_W-1:0] POS_RESET = 16'h0000;
    localparam logic [FAULT_W-1:0] FAULT_RESET = 8'h00;
endpackage

// ### test/rdc_host_port_sequencing_test.sv
// Self-checking bench for the converter host port
`timescale 1ns/100ps
`default_nettype none
module rdc_host_port_sequencing_test;
    import rhp_pkg::*;
    logic CLK_SYS = 1'b0, RST = 1'b1, SAMPLE_N = 1'b1, CHIP_SELECT_N = 1'b1, READ_N = 1'b1;
    logic WRITE_STROBE_FRAME_SYNC_N = 1'b1, SERIAL_PORT_SELECT = 1'b1, SERIAL_DATA_IN, SERIAL_CLK;
    logic MODE_SELECT_LOW = 1'b0, MODE_SELECT_HIGH = 1'b0, SERIAL_DATA_OUT, SERIAL_DATA_OE;
    logic [POS_W-1:0] POSITION_IN = 16'h0000, VELOCITY_IN = 16'h0000, hbus = 16'h0000;
    logic [POS_W-1:0] PARALLEL_DATA_LINES_IN, PARALLEL_DATA_LINES_OUT, pos, vel;
    logic [FAULT_W-1:0] FAULT_IN = 8'h00, flt, a, d;
    logic [CFG_DATA_W-1:0] CONFIG_ADDR, CONFIG_DATA, SERIAL_RX_WORD;
    logic PARALLEL_DATA_LINES_OE, CONFIG_WRITE, SERIAL_RX_VALID;
    logic [23:0] rx, tx;
    logic [1:0] modes [3] = '{MODE_POSITION, MODE_VELOCITY, MODE_CONFIG};
    int n_errors = 0, cmp_count = 0, n_wr = 0, n_rx = 0;
    assign PARALLEL_DATA_LINES_IN = PARALLEL_DATA_LINES_OE ? PARALLEL_DATA_LINES_OUT : hbus;
    rhp_host_port dut (.*);
    rhp_host_serial host (.sclk(SERIAL_CLK), .sdi(SERIAL_DATA_IN), .sdo(SERIAL_DATA_OUT));
    initial begin
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        if (CONFIG_WRITE === 1'b1) n_wr++;
        if (SERIAL_RX_VALID === 1'b1) n_rx++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask
    function automatic logic [15:0] sel(input logic [1:0] m);
        return m == MODE_VELOCITY ? vel : pos;
    endfunction
    // Live inputs are inverted after the fall so a missed latch shows
    task automatic take_sample();
        pos = 16'($urandom);
        vel = 16'($urandom);
        flt = 8'($urandom);
        {POSITION_IN, VELOCITY_IN, FAULT_IN} = {pos, vel, flt};
        cyc(2);
        SAMPLE_N = 1'b0;
        cyc(5);
        SAMPLE_N = 1'b1;
        {POSITION_IN, VELOCITY_IN, FAULT_IN} = ~{pos, vel, flt};
        cyc(10);
    endtask
    task automatic par_read(input logic [1:0] m);
        {MODE_SELECT_HIGH, MODE_SELECT_LOW} = m;
        CHIP_SELECT_N = 1'b0;
        READ_N = 1'b0;
        cyc(5);
        chk({8'h00, PARALLEL_DATA_LINES_OUT}, m == MODE_CONFIG ? {16'h0000, flt} : {8'h00, sel(m)});
        READ_N = 1'b1;
        cyc(1);
        CHIP_SELECT_N = 1'b1;
        cyc(5);
        chk({23'h000000, PARALLEL_DATA_LINES_OE}, 24'h000000);
    endtask
    task automatic wr(input logic [7:0] v);
        hbus = {8'h00, v};
        WRITE_STROBE_FRAME_SYNC_N = 1'b0;
        cyc(3);
        WRITE_STROBE_FRAME_SYNC_N = 1'b1;
        cyc(10);
    endtask
    task automatic ser_read(input logic [1:0] m, input int n);
        int r0;
        r0 = n_rx;
        {MODE_SELECT_HIGH, MODE_SELECT_LOW} = m;
        tx = 24'($urandom);
        cyc(1);
        WRITE_STROBE_FRAME_SYNC_N = 1'b0;
        cyc(2);
        #3.3 host.frame(n, tx, rx);
        cyc(1);
        WRITE_STROBE_FRAME_SYNC_N = 1'b1;
        cyc(6);
        chk(rx, n == 24 ? {sel(m), flt} : {8'h00, sel(m)});
        chk({16'h0000, SERIAL_RX_WORD}, {16'h0000, n == 24 ? tx[7:0] : tx[15:8]});
        chk(24'(n_rx - r0), n == 24 ? 24'h000003 : 24'h000002);
        chk({23'h000000, SERIAL_DATA_OE}, 24'h000000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(79960));
        cyc(20);
        RST = 1'b0;
        cyc(3);
        repeat (3) begin
            take_sample();
            foreach (modes[i]) par_read(modes[i]);
        end
        CHIP_SELECT_N = 1'b0;
        {MODE_SELECT_HIGH, MODE_SELECT_LOW} = MODE_CONFIG;
        for (int k = 1; k < 4; k++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            wr(a);
            wr(d);
            chk({16'h0000, CONFIG_ADDR}, {16'h0000, a});
            chk({16'h0000, CONFIG_DATA}, {16'h0000, d});
            chk(24'(n_wr), 24'(k));
        end
        SERIAL_PORT_SELECT = 1'b0;
        repeat (2) begin
            take_sample();
            ser_read(MODE_POSITION, 24);
            take_sample();
            ser_read(MODE_VELOCITY, 16);
        end
        conclude();
    end
endmodule
`default_nettype wire

// ### test/rhp_host_port_sva.sv
// Concurrent checks on the converter host port pins
`timescale 1ns/100ps
`default_nettype none
module rhp_host_port_sva (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_N,
    input wire logic WRITE_STROBE_FRAME_SYNC_N,
    input wire logic SERIAL_PORT_SELECT,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_DATA_OE,
    input wire logic PARALLEL_DATA_LINES_OE,
    input wire logic CONFIG_WRITE,
    input wire logic SERIAL_RX_VALID
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    property p_par_on; (!READ_N && !CHIP_SELECT_N && SERIAL_PORT_SELECT) [*4]
        |-> PARALLEL_DATA_LINES_OE; endproperty
    a_par_on: assert property (p_par_on) else $error("bus not driven");
    property p_par_off; $rose(READ_N || CHIP_SELECT_N)
        |-> ##[1:4] !PARALLEL_DATA_LINES_OE; endproperty
    a_par_off: assert property (p_par_off) else $error("bus not released");
    property p_par_ser; !SERIAL_PORT_SELECT [*4] |-> !PARALLEL_DATA_LINES_OE; endproperty
    a_par_ser: assert property (p_par_ser) else $error("bus driven in serial");
    property p_sdo_fs; SERIAL_DATA_OE
        |-> !WRITE_STROBE_FRAME_SYNC_N && !SERIAL_PORT_SELECT; endproperty
    a_sdo_fs: assert property (p_sdo_fs) else $error("serial out outside frame");
    property p_oe_rise; $rose(SERIAL_DATA_OE) |-> SERIAL_CLK; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("serial out early");
    property p_sdo_hold; SERIAL_CLK && $past(SERIAL_CLK) |-> $stable(SERIAL_DATA_OUT); endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("serial bit moved");
    property p_cfg_pulse; CONFIG_WRITE |=> !CONFIG_WRITE; endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("write pulse long");
    property p_rx_pulse; SERIAL_RX_VALID |=> !SERIAL_RX_VALID; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse long");
endmodule
bind rhp_host_port rhp_host_port_sva u_sva (.*);
`default_nettype wire

// ### test/rhp_host_serial.sv
// Host model of the serial link clock and data
`timescale 1ns/100ps
`default_nettype none
module rhp_host_serial (
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Clock stands low between frames; idle data flips so a stale bit never matches
    task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h000000;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            #20 sdi = tx[23-i];
            #42.5 sclk = 1'b0;
            rx = {rx[22:0], sdo};
            #62.5;
        end
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire
